//--- rtl/atmrb_regs.svh
// register offsets, field positions and reset values of the trim and mode bank
`ifndef ATMRB_REGS_SVH
`define ATMRB_REGS_SVH

`define ATMRB_OFS_PERF_A      8'h02
`define ATMRB_OFS_BAND_A      8'h58
`define ATMRB_OFS_SHIFT_A     8'hBF
`define ATMRB_OFS_SHIFT_B     8'hC1
`define ATMRB_OFS_LOOP_CTL    8'hCF
`define ATMRB_OFS_PERF_B      8'hD5
`define ATMRB_OFS_PERF_C      8'hD7
`define ATMRB_OFS_PERF_D      8'hDB
`define ATMRB_OFS_SLOW_MASTER 8'hEF
`define ATMRB_OFS_SWING       8'hF1
`define ATMRB_OFS_SLOW_A      8'hF2
// block-local registers: the enables that live elsewhere in the map, and a read-only mode status
`define ATMRB_OFS_DIG_CTL     8'hE0
`define ATMRB_OFS_STATUS      8'hE4

`define ATMRB_RESET_VAL       8'h00
`define ATMRB_BIT_BAND        0
`define ATMRB_SHIFT_MSB       7
`define ATMRB_SHIFT_LSB       4
`define ATMRB_BIT_HOLD        7
`define ATMRB_TAU_MSB         5
`define ATMRB_TAU_LSB         2
`define ATMRB_BIT_SLOW_MASTER 4
`define ATMRB_BIT_SLOW_A      3
`define ATMRB_BIT_SLOW_B      0
`define ATMRB_SWING_OFF       2'h0
`define ATMRB_SWING_ON        2'h3
`define ATMRB_BIT_PERF_A6     6
`define ATMRB_BIT_PERF_B4     4
`define ATMRB_BIT_PERF_B3     3
`define ATMRB_BIT_PERF_C3     3
`define ATMRB_BIT_PERF_C2     2
`define ATMRB_BIT_PERF_D5     5
`define ATMRB_BIT_LOOP_EN     5
`define ATMRB_BIT_DIG_EN      3
`define ATMRB_ADC_WIDTH       12
`define ATMRB_MIDCODE         12'h800

`endif

//--- rtl/atmrb_pkg.sv
// shared types of the trim and mode bank
package atmrb_pkg;

    typedef struct packed {
        logic [7:0] perfA;
        logic [7:0] bandA;
        logic [7:0] shiftA;
        logic [7:0] shiftB;
        logic [7:0] loopCtl;
        logic [7:0] perfB;
        logic [7:0] perfC;
        logic [7:0] perfD;
        logic [7:0] slowMaster;
        logic [7:0] swing;
        logic [7:0] slowA;
        logic [7:0] digCtl;
    } atmrb_regs_t;

    typedef struct packed {
        logic upperBandA;
        logic slowRateA;
        logic slowRateB;
        logic swingOverride;
        logic perfBoostAll;
        logic loopActive;
        logic holdActive;
        logic [3:0] offsetLoopTau;
    } atmrb_mode_t;

    typedef enum logic [1:0] {
        ATMRB_IDLE = 2'b00,
        ATMRB_ACK  = 2'b01
    } atmrb_bus_t;

    typedef struct packed {
        atmrb_bus_t busState;
        logic [7:0] datOut;
        logic ackOut;
        atmrb_regs_t regs;
        atmrb_mode_t mode;
        logic [11:0] levelA;
        logic [11:0] levelB;
    } atmrb_state_t;

endpackage : atmrb_pkg

//--- rtl/atmrb_level_map.sv
// converged output level of one channel from its signed shift field
`timescale 1ns/1ps
`include "atmrb_regs.svh"

module atmrb_level_map #(
    parameter int WIDTH = `ATMRB_ADC_WIDTH
) (
    input wire logic [3:0] shiftCode,
    input wire logic active,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] midcode;
    logic [WIDTH-1:0] extended;

    assign midcode = WIDTH'(`ATMRB_MIDCODE);
    // ---------------------------------------------------------------
    // R3 two's complement field
    // ---------------------------------------------------------------
    // R16 one code per step
    assign extended = {{(WIDTH-4){shiftCode[3]}}, shiftCode};
    // R2 shift added to midcode
    assign level = active ? WIDTH'(midcode + extended) : midcode;
endmodule : atmrb_level_map

//--- rtl/atmrb_slow_gate.sv
// gates the per-channel slow-rate bits with the master bit
`timescale 1ns/1ps

module atmrb_slow_gate #(
    parameter int CHANNELS = 2
) (
    input wire logic master,
    input wire logic [CHANNELS-1:0] chanBits,
    output logic [CHANNELS-1:0] chanSlow
);
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++) begin : gGate
            // R7 master gates channels
            assign chanSlow[i] = master & chanBits[i];
        end
    endgenerate
endmodule : atmrb_slow_gate

//--- rtl/atmrb_bank.sv
// wishbone register bank for channel trim, offset loop and speed modes
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "atmrb_regs.svh"

// Summary of operation
// R1 - band bit selects above-200 MHz mode
// R2 - converged level is midcode plus shift
// R3 - shift field is signed -8 to +7
// R4 - each channel has its own shift
// R5 - hold bit freezes estimate when enabled
// R6 - four-bit loop time constant field
// R7 - master bit gates per-channel slow modes
// R8 - channel A slow bit needs master first
// R9 - channel B slow bit needs master first
// R10 - swing override: 00 off, 11 on
// R11 - software sets six boost bits above 160 MSPS
// R12 - software writes zero to unassigned bits
// R13 - all registers reset to zero
// R14 - loop enable gates hold and shift
// R15 - digital enable gates all digital features; the code gates only the offset loop, hold and levels
// R16 - each shift step moves one code
module atmrb_bank #(
    parameter int ADC_WIDTH = `ATMRB_ADC_WIDTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic upperBandA,
    output logic chanASlowRateEnable,
    output logic chanBSlowRateEnable,
    output logic swingOverride,
    output logic perfBoostAll,
    output logic offsetLoopActive,
    output logic holdOffsetEstimate,
    output logic [3:0] offsetLoopTau,
    output logic [ADC_WIDTH-1:0] chanALevel,
    output logic [ADC_WIDTH-1:0] chanBLevel
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    atmrb_pkg::atmrb_state_t state_reg;
    atmrb_pkg::atmrb_state_t state_next;
    logic [1:0] slowBits;
    logic [1:0] slowGated;
    logic [ADC_WIDTH-1:0] levelA;
    logic [ADC_WIDTH-1:0] levelB;
    logic loopOn;
    logic request;

    function automatic logic [7:0] read_mux(input atmrb_pkg::atmrb_regs_t r,
                                            input atmrb_pkg::atmrb_mode_t m,
                                            input logic [7:0] adr);
        logic [7:0] v;
        v = 8'h00;
        unique case (adr)
            `ATMRB_OFS_PERF_A: v = r.perfA;
            `ATMRB_OFS_BAND_A: v = r.bandA;
            `ATMRB_OFS_SHIFT_A: v = r.shiftA;
            `ATMRB_OFS_SHIFT_B: v = r.shiftB;
            `ATMRB_OFS_LOOP_CTL: v = r.loopCtl;
            `ATMRB_OFS_PERF_B: v = r.perfB;
            `ATMRB_OFS_PERF_C: v = r.perfC;
            `ATMRB_OFS_PERF_D: v = r.perfD;
            `ATMRB_OFS_SLOW_MASTER: v = r.slowMaster;
            `ATMRB_OFS_SWING: v = r.swing;
            `ATMRB_OFS_SLOW_A: v = r.slowA;
            `ATMRB_OFS_DIG_CTL: v = r.digCtl;
            `ATMRB_OFS_STATUS: v = {1'b0, m.loopActive, m.holdActive, m.swingOverride,
                                    m.perfBoostAll, m.slowRateB, m.slowRateA, m.upperBandA};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    assign request = wb_cyc_i & wb_stb_i;

    // R15 digital enable and R14 loop enable
    assign loopOn = state_reg.regs.digCtl[`ATMRB_BIT_DIG_EN]
                    & state_reg.regs.digCtl[`ATMRB_BIT_LOOP_EN];

    assign slowBits = {state_reg.regs.perfD[`ATMRB_BIT_SLOW_B],
                       state_reg.regs.slowA[`ATMRB_BIT_SLOW_A]};

    // R8 channel A slow gated
    // R9 channel B slow gated
    atmrb_slow_gate #(
        .CHANNELS(2)
    ) u_slow (
        .master(state_reg.regs.slowMaster[`ATMRB_BIT_SLOW_MASTER]),
        .chanBits(slowBits),
        .chanSlow(slowGated)
    );

    // R4 independent channel shifts
    atmrb_level_map #(
        .WIDTH(ADC_WIDTH)
    ) u_level_a (
        .shiftCode(state_reg.regs.shiftA[`ATMRB_SHIFT_MSB:`ATMRB_SHIFT_LSB]),
        .active(loopOn),
        .level(levelA)
    );

    atmrb_level_map #(
        .WIDTH(ADC_WIDTH)
    ) u_level_b (
        .shiftCode(state_reg.regs.shiftB[`ATMRB_SHIFT_MSB:`ATMRB_SHIFT_LSB]),
        .active(loopOn),
        .level(levelB)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.ackOut = 1'b0;
        unique case (state_reg.busState)
            atmrb_pkg::ATMRB_IDLE: begin
                // one wait state then ack; the second cycle drops ack again
                if (request) begin
                    state_next.busState = atmrb_pkg::ATMRB_ACK;
                    state_next.ackOut = 1'b1;
                    state_next.datOut = read_mux(state_reg.regs, state_reg.mode, wb_adr_i);
                    if (wb_we_i && wb_sel_i) begin
                        // unassigned bits are stored as written; software keeps them zero
                        unique case (wb_adr_i)
                            `ATMRB_OFS_PERF_A: state_next.regs.perfA = wb_dat_i;
                            `ATMRB_OFS_BAND_A: state_next.regs.bandA = wb_dat_i;
                            `ATMRB_OFS_SHIFT_A: state_next.regs.shiftA = wb_dat_i;
                            `ATMRB_OFS_SHIFT_B: state_next.regs.shiftB = wb_dat_i;
                            `ATMRB_OFS_LOOP_CTL: state_next.regs.loopCtl = wb_dat_i;
                            `ATMRB_OFS_PERF_B: state_next.regs.perfB = wb_dat_i;
                            `ATMRB_OFS_PERF_C: state_next.regs.perfC = wb_dat_i;
                            `ATMRB_OFS_PERF_D: state_next.regs.perfD = wb_dat_i;
                            `ATMRB_OFS_SLOW_MASTER: state_next.regs.slowMaster = wb_dat_i;
                            `ATMRB_OFS_SWING: state_next.regs.swing = wb_dat_i;
                            `ATMRB_OFS_SLOW_A: state_next.regs.slowA = wb_dat_i;
                            `ATMRB_OFS_DIG_CTL: state_next.regs.digCtl = wb_dat_i;
                            default: state_next.regs = state_reg.regs;
                        endcase
                    end
                end
            end
            atmrb_pkg::ATMRB_ACK: begin
                state_next.busState = atmrb_pkg::ATMRB_IDLE;
            end
            default: state_next.busState = atmrb_pkg::ATMRB_IDLE;
        endcase

        // R1 upper band mode
        state_next.mode.upperBandA = state_reg.regs.bandA[`ATMRB_BIT_BAND];
        state_next.mode.slowRateA = slowGated[0];
        state_next.mode.slowRateB = slowGated[1];
        // R10 only 11 enables override
        state_next.mode.swingOverride = (state_reg.regs.swing[1:0] == `ATMRB_SWING_ON);
        // R11 boost flag for the status register and the perfBoostAll output
        state_next.mode.perfBoostAll = state_reg.regs.perfA[`ATMRB_BIT_PERF_A6]
                                     & state_reg.regs.perfB[`ATMRB_BIT_PERF_B4]
                                     & state_reg.regs.perfB[`ATMRB_BIT_PERF_B3]
                                     & state_reg.regs.perfC[`ATMRB_BIT_PERF_C3]
                                     & state_reg.regs.perfC[`ATMRB_BIT_PERF_C2]
                                     & state_reg.regs.perfD[`ATMRB_BIT_PERF_D5];
        state_next.mode.loopActive = loopOn;
        // R5 hold only while loop on
        state_next.mode.holdActive = loopOn & state_reg.regs.loopCtl[`ATMRB_BIT_HOLD];
        // R6 loop time constant
        state_next.mode.offsetLoopTau = state_reg.regs.loopCtl[`ATMRB_TAU_MSB:`ATMRB_TAU_LSB];
        state_next.levelA = levelA;
        state_next.levelB = levelB;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        // R13 everything resets to zero except the two levels, which load midcode
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.levelA <= ADC_WIDTH'(`ATMRB_MIDCODE);
            state_reg.levelB <= ADC_WIDTH'(`ATMRB_MIDCODE);
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o = state_reg.datOut;
    assign wb_ack_o = state_reg.ackOut;
    assign upperBandA = state_reg.mode.upperBandA;
    assign chanASlowRateEnable = state_reg.mode.slowRateA;
    assign chanBSlowRateEnable = state_reg.mode.slowRateB;
    assign swingOverride = state_reg.mode.swingOverride;
    assign perfBoostAll = state_reg.mode.perfBoostAll;
    assign offsetLoopActive = state_reg.mode.loopActive;
    assign holdOffsetEstimate = state_reg.mode.holdActive;
    assign offsetLoopTau = state_reg.mode.offsetLoopTau;
    assign chanALevel = state_reg.levelA;
    assign chanBLevel = state_reg.levelB;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // bus ack one cycle
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (sys_rst) // bus
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

    // R1 band follows bit
    a_band_follows: assert property (@(posedge clk) disable iff (sys_rst) // R1
        ##1 upperBandA == $past(state_reg.regs.bandA[0])) else $error("band mode wrong");

    // R8 channel A gated
    a_slow_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        !$past(state_reg.regs.slowMaster[4]) |-> !chanASlowRateEnable)
        else $error("channel A slow without master");

    // R9 channel B set
    a_slow_gate_b: assert property (@(posedge clk) disable iff (sys_rst) // R9
        ($past(state_reg.regs.slowMaster[4]) && $past(state_reg.regs.perfD[0]))
        |-> chanBSlowRateEnable) else $error("channel B slow not set");

    // R10 override needs 11
    a_swing_code: assert property (@(posedge clk) disable iff (sys_rst) // R10
        swingOverride |-> $past(state_reg.regs.swing[1:0]) == 2'h3)
        else $error("swing override from illegal code");

    // R5 hold needs loop
    a_hold_needs_loop: assert property (@(posedge clk) disable iff (sys_rst) // R5
        holdOffsetEstimate |-> offsetLoopActive) else $error("hold without loop");

    // R15 loop needs digital
    a_loop_gated: assert property (@(posedge clk) disable iff (sys_rst) // R15
        offsetLoopActive |-> $past(state_reg.regs.digCtl[3])) else $error("loop without digital");

    // R2 midcode when off
    a_level_mid: assert property (@(posedge clk) disable iff (sys_rst) // R2
        !$past(loopOn) |-> chanALevel == 12'h800) else $error("level off midcode");

    // R3 minus eight
    a_level_shift: assert property (@(posedge clk) disable iff (sys_rst) // R3
        ($past(loopOn) && $past(state_reg.regs.shiftB[7:4]) == 4'h8) |-> chanBLevel == 12'h7F8)
        else $error("minus eight shift wrong");

    // R6 tau copied out
    a_tau_copy: assert property (@(posedge clk) disable iff (sys_rst) // R6
        offsetLoopTau == $past(state_reg.regs.loopCtl[5:2])) else $error("tau mismatch");

    // R4 shift A write
    a_write_takes: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (request && !wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == 8'hBF)
        |=> state_reg.regs.shiftA == $past(wb_dat_i)) else $error("shift A write lost");

    // R4 shift B write
    a_write_shift_b: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (request && !wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == 8'hC1)
        |=> state_reg.regs.shiftB == $past(wb_dat_i)) else $error("shift B write lost");

    // ---------------------------------------------------------------
    // reset and mode checks
    // ---------------------------------------------------------------
    // R13 registers cleared
    a_reset_regs: assert property (@(posedge clk) // R13
        sys_rst |=> (state_reg.regs == '0 && !wb_ack_o))
        else $error("registers not cleared by reset");

    // R13 levels at midcode
    a_reset_levels: assert property (@(posedge clk) // R13
        sys_rst |=> (chanALevel == 12'h800 && chanBLevel == 12'h800))
        else $error("levels not at midcode after reset");

    // R13 modes cleared
    a_reset_modes: assert property (@(posedge clk) // R13
        sys_rst |=> state_reg.mode == '0)
        else $error("modes not cleared by reset");

    // R3 plus seven
    a_level_plus: assert property (@(posedge clk) disable iff (sys_rst) // R3
        ($past(loopOn) && $past(state_reg.regs.shiftA[7:4]) == 4'h7) |-> chanALevel == 12'h807)
        else $error("plus seven shift wrong");

    // R3 minus one
    a_level_minus: assert property (@(posedge clk) disable iff (sys_rst) // R3
        ($past(loopOn) && $past(state_reg.regs.shiftA[7:4]) == 4'hF) |-> chanALevel == 12'h7FF)
        else $error("minus one shift wrong");

    // R2 zero shift midcode
    a_level_zero: assert property (@(posedge clk) disable iff (sys_rst) // R2
        ($past(loopOn) && $past(state_reg.regs.shiftA[7:4]) == 4'h0) |-> chanALevel == 12'h800)
        else $error("zero shift off midcode");

    // R4 channel B shift
    a_level_b_plus: assert property (@(posedge clk) disable iff (sys_rst) // R4
        ($past(loopOn) && $past(state_reg.regs.shiftB[7:4]) == 4'h7) |-> chanBLevel == 12'h807)
        else $error("channel B plus seven wrong");

    // R14 loop off midcode
    a_level_b_mid: assert property (@(posedge clk) disable iff (sys_rst) // R14
        !$past(loopOn) |-> chanBLevel == 12'h800)
        else $error("channel B level off midcode");

    // R8 channel A slow
    a_slow_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        ($past(state_reg.regs.slowMaster[4]) && $past(state_reg.regs.slowA[3]))
        |-> chanASlowRateEnable) else $error("channel A slow not set");

    // R7 master gates B
    a_slow_off_b: assert property (@(posedge clk) disable iff (sys_rst) // R7
        !$past(state_reg.regs.slowMaster[4]) |-> !chanBSlowRateEnable)
        else $error("channel B slow without master");

    // R10 code 11 enables
    a_swing_on: assert property (@(posedge clk) disable iff (sys_rst) // R10
        $past(state_reg.regs.swing[1:0]) == 2'h3 |-> swingOverride)
        else $error("swing override missing");

    // R11 boost needs perfA bit 6
    a_boost_needs_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
        !$past(state_reg.regs.perfA[6]) |-> !perfBoostAll)
        else $error("boost flag without bit six");

    // R5 hold when frozen
    a_hold_set: assert property (@(posedge clk) disable iff (sys_rst) // R5
        ($past(loopOn) && $past(state_reg.regs.loopCtl[7])) |-> holdOffsetEstimate)
        else $error("hold bit not applied");

    // R14 loop needs enable
    a_loop_needs_en: assert property (@(posedge clk) disable iff (sys_rst) // R14
        offsetLoopActive |-> $past(state_reg.regs.digCtl[5]))
        else $error("loop without its enable");

    // R15 loop follows enables
    a_loop_on: assert property (@(posedge clk) disable iff (sys_rst) // R15
        $past(loopOn) |-> offsetLoopActive)
        else $error("loop not active");

endmodule : atmrb_bank

//--- dv/atmrb_bank_bench.sv
// self-checking bench of the trim and mode bank
`timescale 1ns/1ps
`include "atmrb_regs.svh"

module atmrb_bank_bench;
    logic clk;
    logic sysRst;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [7:0] wbDatI;
    logic wbSel;
    logic [7:0] wbDatO;
    logic wbAck;
    logic bandA;
    logic slowA;
    logic slowB;
    logic swing;
    logic boost;
    logic loopOn;
    logic hold;
    logic [3:0] tau;
    logic [11:0] levelA;
    logic [11:0] levelB;
    int errors;
    int samples_checked;

    atmrb_bank DUT (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .upperBandA(bandA),
        .chanASlowRateEnable(slowA), .chanBSlowRateEnable(slowB), .swingOverride(swing),
        .perfBoostAll(boost), .offsetLoopActive(loopOn), .holdOffsetEstimate(hold),
        .offsetLoopTau(tau), .chanALevel(levelA), .chanBLevel(levelB));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // compares and bus cycles
    // ----------------------------------------
    task automatic check_out(input logic [11:0] act, input logic [11:0] exp);
        samples_checked++;
        if (act !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask : check_out

    task automatic check_bit(input logic act, input logic exp);
        check_out({11'h000, act}, {11'h000, exp});
    endtask : check_bit

    // ack and read data are taken at the rising edge; the request stands until then
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat,
        input logic sel, output logic [7:0] rdat);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= dat;
        wbSel <= sel;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) check_bit(wbAck, 1'b1);
        rdat = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [7:0] d;
        wb_cycle(1'b1, adr, dat, 1'b1, d);
        repeat (3) @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] d;
        wb_cycle(1'b0, adr, 8'h00, 1'b1, d);
        check_out({4'h0, d}, {4'h0, exp});
    endtask : rd

    function automatic logic [11:0] lvl(input logic [3:0] c);
        return `ATMRB_MIDCODE + {{8{c[3]}}, c};
    endfunction : lvl

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        logic [7:0] ofs [12] = '{`ATMRB_OFS_PERF_A, `ATMRB_OFS_BAND_A, `ATMRB_OFS_SHIFT_A,
            `ATMRB_OFS_SHIFT_B, `ATMRB_OFS_LOOP_CTL, `ATMRB_OFS_PERF_B, `ATMRB_OFS_PERF_C,
            `ATMRB_OFS_PERF_D, `ATMRB_OFS_SLOW_MASTER, `ATMRB_OFS_SWING, `ATMRB_OFS_SLOW_A,
            `ATMRB_OFS_DIG_CTL};
        check_out({1'b0, bandA, slowA, slowB, swing, boost, loopOn, hold, tau}, 12'h000);
        check_out(levelA, 12'h800);
        check_out(levelB, 12'h800);
        for (int i = 0; i < 12; i++) rd(ofs[i], 8'h00);
        $display("test reset done");
    endtask : test_reset

    task automatic test_band;
        wr(`ATMRB_OFS_BAND_A, 8'h01);
        check_bit(bandA, 1'b1);
        rd(`ATMRB_OFS_BAND_A, 8'h01);
        rd(`ATMRB_OFS_STATUS, 8'h01);
        wr(`ATMRB_OFS_BAND_A, 8'h00);
        check_bit(bandA, 1'b0);
        $display("test band done");
    endtask : test_band

    task automatic test_levels;
        logic [3:0] c;
        wr(`ATMRB_OFS_DIG_CTL, 8'h28);
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            wr(`ATMRB_OFS_SHIFT_A, {c, 4'h0});
            wr(`ATMRB_OFS_SHIFT_B, {~c, 4'h0});
            check_out(levelA, lvl(c));
            check_out(levelB, lvl(~c));
        end
        wr(`ATMRB_OFS_DIG_CTL, 8'h20);
        check_out(levelA, 12'h800);
        check_bit(loopOn, 1'b0);
        wr(`ATMRB_OFS_DIG_CTL, 8'h08);
        check_out(levelB, 12'h800);
        check_bit(loopOn, 1'b0);
        $display("test levels done");
    endtask : test_levels

    task automatic test_hold;
        wr(`ATMRB_OFS_DIG_CTL, 8'h28);
        for (int t = 0; t < 16; t++) begin
            wr(`ATMRB_OFS_LOOP_CTL, {2'b10, 4'(t), 2'b00});
            check_bit(hold, 1'b1);
            check_out({8'h00, tau}, 12'(t));
        end
        wr(`ATMRB_OFS_DIG_CTL, 8'h08);
        check_bit(hold, 1'b0);
        wr(`ATMRB_OFS_DIG_CTL, 8'h28);
        wr(`ATMRB_OFS_LOOP_CTL, 8'h00);
        check_bit(hold, 1'b0);
        $display("test hold done");
    endtask : test_hold

    task automatic test_slow;
        wr(`ATMRB_OFS_SLOW_A, 8'h08);
        wr(`ATMRB_OFS_PERF_D, 8'h01);
        check_out({10'h000, slowA, slowB}, 12'h000);
        wr(`ATMRB_OFS_SLOW_MASTER, 8'h10);
        check_bit(slowA, 1'b1);
        check_bit(slowB, 1'b1);
        wr(`ATMRB_OFS_SLOW_A, 8'h00);
        check_out({10'h000, slowA, slowB}, 12'h001);
        wr(`ATMRB_OFS_SLOW_MASTER, 8'h00);
        check_bit(slowB, 1'b0);
        $display("test slow done");
    endtask : test_slow

    task automatic test_swing;
        for (int s = 0; s < 4; s++) begin
            wr(`ATMRB_OFS_SWING, (s % 2 == 0) ? 8'h03 : 8'h00);
            check_bit(swing, s % 2 == 0);
        end
        $display("test swing done");
    endtask : test_swing

    // every one of the six bits is removed in turn; a missing term would stay high
    task automatic test_boost;
        logic [7:0] adr [4] = '{`ATMRB_OFS_PERF_A, `ATMRB_OFS_PERF_B, `ATMRB_OFS_PERF_C,
            `ATMRB_OFS_PERF_D};
        logic [7:0] val [4] = '{8'h40, 8'h18, 8'h0C, 8'h20};
        logic [7:0] lone [6] = '{8'h40, 8'h10, 8'h08, 8'h08, 8'h04, 8'h20};
        int reg6 [6] = '{0, 1, 1, 2, 2, 3};
        for (int i = 0; i < 4; i++) wr(adr[i], val[i]);
        check_bit(boost, 1'b1);
        for (int i = 0; i < 6; i++) begin
            wr(adr[reg6[i]], val[reg6[i]] & ~lone[i]);
            check_bit(boost, 1'b0);
            wr(adr[reg6[i]], val[reg6[i]]);
        end
        check_bit(boost, 1'b1);
        rd(`ATMRB_OFS_STATUS, 8'h48);
        $display("test boost done");
    endtask : test_boost

    task automatic test_bus;
        logic [7:0] d;
        wr(8'h55, 8'hAA);
        rd(8'h55, 8'h00);
        wb_cycle(1'b1, `ATMRB_OFS_BAND_A, 8'h01, 1'b0, d);
        rd(`ATMRB_OFS_BAND_A, 8'h00);
        $display("test bus done");
    endtask : test_bus

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic complete_run;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // the whole sequence needs about five hundred cycles
    initial begin
        #400000;
        errors++;
        complete_run;
    end

    initial begin
        errors = 0;
        samples_checked = 0;
        sysRst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbDatI = 8'h00;
        wbSel = 1'b0;
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        @(negedge clk);
        test_reset;
        test_band;
        test_levels;
        test_hold;
        test_slow;
        test_swing;
        test_boost;
        test_bus;
        @(posedge clk);
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        @(negedge clk);
        test_reset;
        complete_run;
    end
endmodule : atmrb_bank_bench
